// File: src/hotplug_slot_control.sv
// Hot-plug slot control register bank with event flags, interrupt and slot outputs
//
// Functional notes
// - Bit 0 lets an attention-button press raise interrupt or wake-up.
// - Bit 1 lets a power fault raise interrupt or wake-up.
// - Bit 2 lets a latch sensor change raise interrupt or wake-up.
// - Bit 3 lets a presence change raise interrupt or wake-up; never capability gated.
// - Bit 4 lets command completion raise an interrupt, never a wake-up.
// - Bit 5 master enable; when clear no hot-plug interrupt at all.
// - Bits 7:6 set and report attention indicator; reset off.
// - Attention field reads zero without the attention indicator capability.
// - Bits 9:8 set and report power indicator; reset on.
// - Power indicator field reads zero without the power indicator capability.
// - On the upstream port power indicator writes never reach the indicator.
// - Bit 10 sets and reports slot power; zero means on.
// - Bit 11 always reads zero.
// - Writing one to bit 11 flips the interlock; zero leaves it.
// - Bit 12 lets a link-active change raise interrupt or wake-up.
// - Capability dependent fields are read-only zero when capability absent.
// - One control write is one command; done flag after external completion.
// - Each event sets its own flag, cleared by writing one.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module hotplug_slot_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hotplug_pkg::ADDR_W-1:0] paddr,
  input wire logic [hotplug_pkg::DATA_W-1:0] pwdata,
  output logic [hotplug_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slot capabilities from the capability register
  input wire logic button_present,
  input wire logic power_ctrl_present,
  input wire logic latch_sensor_present,
  input wire logic attention_led_present,
  input wire logic power_led_present,
  input wire logic interlock_present,
  input wire logic hotplug_capable,
  input wire logic upstream_port,
  // Hot-plug events from the slot
  input wire logic button_pressed,
  input wire logic power_fault,
  input wire logic latch_changed,
  input wire logic presence_changed,
  input wire logic link_active,
  // Command handshake with the slot expander
  output logic cmd_req,
  input wire logic cmd_ack,
  // Slot outputs
  output logic [1:0] attention_led,
  output logic [1:0] power_led,
  output logic slot_power_off,
  output logic interlock_state,
  // Notifications
  output logic hotplug_irq,
  output logic wake_event
);

  // Control fields
  logic button_press_enable_reg;
  logic power_fault_enable_reg;
  logic latch_sensor_change_enable_reg;
  logic presence_change_enable_reg;
  logic cmd_done_irq_enable_reg;
  logic hotplug_irq_master_enable_reg;
  logic [1:0] attention_led_ctrl_reg;
  logic [1:0] power_led_ctrl_reg;
  logic slot_power_ctrl_reg;
  logic link_active_change_enable_reg;

  // Slot side state
  logic [1:0] power_led_reg;
  logic interlock_reg;
  logic link_active_reg;
  logic link_seen_reg;
  logic [hotplug_pkg::DATA_W-1:0] prdata_reg;
  hotplug_pkg::cmd_state_e cmd_state_reg;
  hotplug_pkg::cmd_state_e cmd_state_next;

  // Bus strobes
  logic setup_read;
  logic ctl_write;
  logic sts_write;
  logic cmd_busy;
  logic [hotplug_pkg::NUM_FLAGS-1:0] flags;
  logic [hotplug_pkg::NUM_FLAGS-1:0] flag_set;
  logic [hotplug_pkg::NUM_FLAGS-1:0] flag_clear;
  logic cmd_done;

  // Capability gates: a field is writable only when its capability is present
  wire gate_button = button_present;
  wire gate_fault = power_ctrl_present;
  wire gate_latch = latch_sensor_present;
  wire gate_hotplug = hotplug_capable;
  wire gate_attention = attention_led_present;
  wire gate_power_led = power_led_present;
  wire gate_power = power_ctrl_present;
  wire gate_interlock = interlock_present;

  // Write data fields
  wire wd_button = pwdata[hotplug_pkg::BUTTON_PRESS_ENABLE_BIT];
  wire wd_fault = pwdata[hotplug_pkg::POWER_FAULT_ENABLE_BIT];
  wire wd_latch = pwdata[hotplug_pkg::LATCH_SENSOR_CHANGE_ENABLE_BIT];
  wire wd_presence = pwdata[hotplug_pkg::PRESENCE_CHANGE_ENABLE_BIT];
  wire wd_cmd = pwdata[hotplug_pkg::CMD_DONE_IRQ_ENABLE_BIT];
  wire wd_master = pwdata[hotplug_pkg::HOTPLUG_IRQ_MASTER_ENABLE_BIT];
  wire [1:0] wd_attention = pwdata[hotplug_pkg::ATTENTION_LED_LSB +: 2];
  wire [1:0] wd_power_led = pwdata[hotplug_pkg::POWER_LED_LSB +: 2];
  wire wd_power = pwdata[hotplug_pkg::SLOT_POWER_CTRL_BIT];
  wire wd_toggle = pwdata[hotplug_pkg::INTERLOCK_TOGGLE_BIT];
  wire wd_link = pwdata[hotplug_pkg::LINK_ACTIVE_CHANGE_ENABLE_BIT];

  // APB decode and answer
  hotplug_apb_decode u_decode (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .cmd_busy(cmd_busy),
    .pready(pready),
    .pslverr(pslverr),
    .setup_read(setup_read),
    .ctl_write(ctl_write),
    .sts_write(sts_write)
  );

  // Enable bits, each held only when its capability allows it, except the ungated presence and link-active change enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      button_press_enable_reg <= hotplug_pkg::ENABLE_RESET;
      power_fault_enable_reg <= hotplug_pkg::ENABLE_RESET;
      latch_sensor_change_enable_reg <= hotplug_pkg::ENABLE_RESET;
      presence_change_enable_reg <= hotplug_pkg::ENABLE_RESET;
      cmd_done_irq_enable_reg <= hotplug_pkg::ENABLE_RESET;
      hotplug_irq_master_enable_reg <= hotplug_pkg::ENABLE_RESET;
      link_active_change_enable_reg <= hotplug_pkg::ENABLE_RESET;
    end
    else if (ctl_write)
    begin
      button_press_enable_reg <= wd_button & gate_button;
      power_fault_enable_reg <= wd_fault & gate_fault;
      latch_sensor_change_enable_reg <= wd_latch & gate_latch;
      presence_change_enable_reg <= wd_presence;
      cmd_done_irq_enable_reg <= wd_cmd & gate_hotplug;
      hotplug_irq_master_enable_reg <= wd_master & gate_hotplug;
      link_active_change_enable_reg <= wd_link;
    end
  end

  // Indicator and power control fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      attention_led_ctrl_reg <= hotplug_pkg::ATTENTION_LED_RESET;
      power_led_ctrl_reg <= hotplug_pkg::POWER_LED_RESET;
      slot_power_ctrl_reg <= hotplug_pkg::SLOT_POWER_RESET;
    end
    else if (ctl_write)
    begin
      if (gate_attention)
        attention_led_ctrl_reg <= wd_attention;
      if (gate_power_led)
        power_led_ctrl_reg <= wd_power_led;
      if (gate_power)
        slot_power_ctrl_reg <= wd_power;
    end
  end

  // Power indicator drive; the upstream port never moves it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      power_led_reg <= hotplug_pkg::POWER_LED_RESET;
    else if (ctl_write && gate_power_led && !upstream_port)
      power_led_reg <= wd_power_led;
  end

  // Interlock flips on a written one only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interlock_reg <= hotplug_pkg::INTERLOCK_RESET;
    else if (ctl_write && gate_interlock && wd_toggle)
      interlock_reg <= ~interlock_reg;
  end

  // Link-active sampling; first sample only arms the change detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_active_reg <= 1'b0;
      link_seen_reg <= 1'b0;
    end
    else
    begin
      link_active_reg <= link_active;
      link_seen_reg <= 1'b1;
    end
  end

  // Command sequencer: a control write waits for the expander to finish
  always_comb
  begin
    cmd_state_next = cmd_state_reg;
    unique case (cmd_state_reg)
      hotplug_pkg::CMD_IDLE:
        if (ctl_write)
          cmd_state_next = hotplug_pkg::CMD_WAIT;
      hotplug_pkg::CMD_WAIT:
        if (cmd_ack)
          cmd_state_next = hotplug_pkg::CMD_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_state_reg <= hotplug_pkg::CMD_IDLE;
    else
      cmd_state_reg <= cmd_state_next;
  end

  // Busy holds off a second command; done marks the end of the first
  assign cmd_busy = (cmd_state_reg == hotplug_pkg::CMD_WAIT);
  assign cmd_done = cmd_busy & cmd_ack;
  assign cmd_req = cmd_busy;

  // Event set pulses in flag order
  always_comb
  begin
    flag_set = '0;
    flag_set[hotplug_pkg::FLAG_BUTTON] = button_pressed;
    flag_set[hotplug_pkg::FLAG_POWER_FAULT] = power_fault;
    flag_set[hotplug_pkg::FLAG_LATCH] = latch_changed;
    flag_set[hotplug_pkg::FLAG_PRESENCE] = presence_changed;
    flag_set[hotplug_pkg::FLAG_CMD_DONE] = cmd_done;
    flag_set[hotplug_pkg::FLAG_LINK] = link_seen_reg & (link_active != link_active_reg);
  end

  // Write-one clears taken from the status layout
  always_comb
  begin
    flag_clear = '0;
    if (sts_write)
    begin
      flag_clear[hotplug_pkg::NUM_FLAGS-2:0] = pwdata[hotplug_pkg::NUM_FLAGS-2:0];
      flag_clear[hotplug_pkg::FLAG_LINK] = pwdata[hotplug_pkg::STS_LINK_BIT];
    end
  end

  // Sticky flags
  hotplug_event_flags #(
    .NUM(hotplug_pkg::NUM_FLAGS)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(flag_set),
    .clear_req(flag_clear),
    .flags(flags)
  );

  // Flags qualified by their own enables
  wire hit_button = flags[hotplug_pkg::FLAG_BUTTON] & button_press_enable_reg;
  wire hit_fault = flags[hotplug_pkg::FLAG_POWER_FAULT] & power_fault_enable_reg;
  wire hit_latch = flags[hotplug_pkg::FLAG_LATCH] & latch_sensor_change_enable_reg;
  wire hit_presence = flags[hotplug_pkg::FLAG_PRESENCE] & presence_change_enable_reg;
  wire hit_cmd = flags[hotplug_pkg::FLAG_CMD_DONE] & cmd_done_irq_enable_reg;
  wire hit_link = flags[hotplug_pkg::FLAG_LINK] & link_active_change_enable_reg;
  wire wake_any = hit_button | hit_fault | hit_latch | hit_presence | hit_link;

  // Interrupt needs the master enable; wake-up ignores it and command done
  assign hotplug_irq = hotplug_irq_master_enable_reg & (wake_any | hit_cmd);
  assign wake_event = wake_any;

  // Control register read view with capability masking
  wire [hotplug_pkg::CTL_W-1:0] ctl_view = {
    3'h0,
    link_active_change_enable_reg,
    1'b0,
    slot_power_ctrl_reg & gate_power,
    power_led_ctrl_reg & {2{gate_power_led}},
    attention_led_ctrl_reg & {2{gate_attention}},
    hotplug_irq_master_enable_reg & gate_hotplug,
    cmd_done_irq_enable_reg & gate_hotplug,
    presence_change_enable_reg,
    latch_sensor_change_enable_reg & gate_latch,
    power_fault_enable_reg & gate_fault,
    button_press_enable_reg & gate_button
  };

  // Status register read view
  wire [hotplug_pkg::CTL_W-1:0] sts_view = {
    7'h00,
    flags[hotplug_pkg::FLAG_LINK],
    interlock_reg & gate_interlock,
    2'h0,
    flags[hotplug_pkg::FLAG_CMD_DONE:0]
  };

  // Read data selection
  wire sel_ctl = (paddr == hotplug_pkg::SLOT_CONTROL_ADDR);
  wire sel_sts = (paddr == hotplug_pkg::SLOT_STATUS_ADDR);
  wire [hotplug_pkg::CTL_W-1:0] rd_view = sel_ctl ? ctl_view : (sel_sts ? sts_view : '0);

  // Read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= '0;
    else if (setup_read)
      prdata_reg <= {16'h0000, rd_view};
  end

  // Slot outputs
  assign prdata = prdata_reg;
  assign attention_led = attention_led_ctrl_reg;
  assign power_led = power_led_reg;
  assign slot_power_off = slot_power_ctrl_reg;
  assign interlock_state = interlock_reg;

endmodule

// File: src/hotplug_pkg.sv
// Package with register map, field layout, reset values and encodings of the slot control block
package hotplug_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CTL_W = 16;

  // Register byte addresses
  localparam logic [11:0] SLOT_CONTROL_ADDR = 12'h058;
  localparam logic [11:0] SLOT_STATUS_ADDR = 12'h05C;

  // Control register field positions
  localparam int BUTTON_PRESS_ENABLE_BIT = 0;
  localparam int POWER_FAULT_ENABLE_BIT = 1;
  localparam int LATCH_SENSOR_CHANGE_ENABLE_BIT = 2;
  localparam int PRESENCE_CHANGE_ENABLE_BIT = 3;
  localparam int CMD_DONE_IRQ_ENABLE_BIT = 4;
  localparam int HOTPLUG_IRQ_MASTER_ENABLE_BIT = 5;
  localparam int ATTENTION_LED_LSB = 6;
  localparam int POWER_LED_LSB = 8;
  localparam int SLOT_POWER_CTRL_BIT = 10;
  localparam int INTERLOCK_TOGGLE_BIT = 11;
  localparam int LINK_ACTIVE_CHANGE_ENABLE_BIT = 12;

  // Indicator encodings
  localparam logic [1:0] LED_RESERVED = 2'h0;
  localparam logic [1:0] LED_ON = 2'h1;
  localparam logic [1:0] LED_BLINK = 2'h2;
  localparam logic [1:0] LED_OFF = 2'h3;

  // Control register reset values
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic [1:0] ATTENTION_LED_RESET = 2'h3;
  localparam logic [1:0] POWER_LED_RESET = 2'h1;
  localparam logic SLOT_POWER_RESET = 1'h0;
  localparam logic INTERLOCK_RESET = 1'h0;

  // Event flag indices inside the flag vector
  localparam int NUM_FLAGS = 6;
  localparam int FLAG_BUTTON = 0;
  localparam int FLAG_POWER_FAULT = 1;
  localparam int FLAG_LATCH = 2;
  localparam int FLAG_PRESENCE = 3;
  localparam int FLAG_CMD_DONE = 4;
  localparam int FLAG_LINK = 5;

  // Status register bit positions
  localparam int STS_INTERLOCK_BIT = 7;
  localparam int STS_LINK_BIT = 8;

  // Command sequencer states
  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_WAIT = 1'b1
  } cmd_state_e;

endpackage

// File: src/hotplug_event_flags.sv
// Sticky event flags, set by hardware pulses and cleared by software writing one
`timescale 1ns/1ns
module hotplug_event_flags #(
  parameter int NUM = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear
  input wire logic [NUM-1:0] set_pulse,
  input wire logic [NUM-1:0] clear_req,
  // Flag state
  output logic [NUM-1:0] flags
);

  // One flag per event; a set in the clearing cycle survives
  genvar i;
  generate
    for (i = 0; i < NUM; i++)
    begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flags[i] <= 1'b0;
        else if (set_pulse[i])
          flags[i] <= 1'b1;
        else if (clear_req[i])
          flags[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// File: src/hotplug_apb_decode.sv
// APB address decode, wait-state and error answer for the slot control registers
`timescale 1ns/1ns
module hotplug_apb_decode (
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hotplug_pkg::ADDR_W-1:0] paddr,
  // Stall while a control command is still running
  input wire logic cmd_busy,
  // APB answer
  output logic pready,
  output logic pslverr,
  // Decoded strobes
  output logic setup_read,
  output logic ctl_write,
  output logic sts_write
);

  // Address matches
  wire hit_ctl = (paddr == hotplug_pkg::SLOT_CONTROL_ADDR);
  wire hit_sts = (paddr == hotplug_pkg::SLOT_STATUS_ADDR);
  wire access = psel & penable;
  wire stall = access & pwrite & hit_ctl & cmd_busy;

  // Answer and strobes; a write takes effect only on the completing edge
  assign pready = ~stall;
  assign pslverr = access & ~(hit_ctl | hit_sts);
  assign setup_read = psel & ~penable & ~pwrite;
  assign ctl_write = access & pwrite & hit_ctl & ~cmd_busy;
  assign sts_write = access & pwrite & hit_sts;

endmodule

// File: bench/hotplug_slot_checker.sv
// Port-level assertions for the slot control register bank
`timescale 1ns/1ns
module hotplug_slot_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hotplug_pkg::ADDR_W-1:0] paddr,
  input wire logic [hotplug_pkg::DATA_W-1:0] pwdata,
  input wire logic [hotplug_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  // Capabilities and slot side
  input wire logic attention_led_present,
  input wire logic power_led_present,
  input wire logic interlock_present,
  input wire logic upstream_port,
  input wire logic cmd_req,
  input wire logic cmd_ack,
  input wire logic [1:0] attention_led,
  input wire logic [1:0] power_led,
  input wire logic interlock_state
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase to the control register, and a completed write to it
  sequence s_ctl_acc;
    psel && penable && paddr == hotplug_pkg::SLOT_CONTROL_ADDR;
  endsequence
  sequence s_ctl_wr;
    s_ctl_acc ##0 (pwrite && pready);
  endsequence
  // Command handshake
  property p_cmd_start; s_ctl_wr |=> cmd_req; endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("no command after write");
  property p_cmd_end; cmd_req && cmd_ack |=> !cmd_req; endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("command not ended");
  property p_cmd_hold; cmd_req && !cmd_ack |=> cmd_req; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped early");
  property p_stall; s_ctl_acc ##0 (pwrite && cmd_req) |-> !pready; endproperty
  a_stall: assert property (p_stall) else $error("second command not stalled");
  // Indicator and interlock outputs
  property p_pled; upstream_port |=> $stable(power_led); endproperty
  a_pled: assert property (p_pled) else $error("power indicator moved on upstream");
  property p_ilk_flip; s_ctl_wr ##0 (interlock_present && pwdata[11]) |=> interlock_state != $past(interlock_state);
  endproperty
  a_ilk_flip: assert property (p_ilk_flip) else $error("interlock not toggled");
  property p_ilk_hold; s_ctl_wr ##0 !pwdata[11] |=> $stable(interlock_state); endproperty
  a_ilk_hold: assert property (p_ilk_hold) else $error("interlock changed");
  property p_att_set; s_ctl_wr ##0 attention_led_present |=> attention_led == $past(pwdata[7:6]); endproperty
  a_att_set: assert property (p_att_set) else $error("attention indicator not set");
  // Read data of the control register
  property p_rd_zero; s_ctl_acc ##0 !pwrite |-> prdata[31:13] == 19'h00000 && !prdata[11]; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reserved or toggle bits not zero");
  property p_att_gate; s_ctl_acc ##0 (!pwrite && !attention_led_present) |-> prdata[7:6] == 2'h0; endproperty
  a_att_gate: assert property (p_att_gate) else $error("attention field not zero");
  property p_pwr_gate; s_ctl_acc ##0 (!pwrite && !power_led_present) |-> prdata[9:8] == 2'h0; endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power indicator field not zero");
endmodule

// File: bench/hotplug_expander_model.sv
// Behavioural slot expander that acknowledges each command after a set delay
`timescale 1ns/1ns
module hotplug_expander_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command handshake
  input wire logic cmd_req,
  input wire logic [3:0] delay,
  output logic cmd_ack
);
  logic [3:0] cnt_reg;
  // Count the expander transaction, then pulse the acknowledge for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 4'h0;
      cmd_ack <= 1'b0;
    end
    else
    begin
      cmd_ack <= cmd_req && !cmd_ack && cnt_reg >= delay;
      cnt_reg <= (cmd_req && !cmd_ack) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule

// File: bench/tb_hotplug_slot_control.sv
// Self-checking testbench for the slot control register bank
`timescale 1ns/1ns
module tb_hotplug_slot_control;
  // Clock, reset and APB
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [hotplug_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [hotplug_pkg::DATA_W-1:0] pwdata = 32'h00000000;
  logic [hotplug_pkg::DATA_W-1:0] prdata;
  logic pready, pslverr;
  // Capabilities, events and slot side
  logic [6:0] cap = 7'h7F;
  logic up = 1'b0;
  logic [3:0] ev = 4'h0;
  logic link = 1'b0;
  logic [3:0] dly = 4'h2;
  logic cmd_req, cmd_ack, slot_power_off, interlock_state, hotplug_irq, wake_event;
  logic [1:0] attention_led, power_led;
  // Bench model state and counters
  logic [15:0] cur;
  logic ilk;
  logic [1:0] pled;
  logic [31:0] rdata;
  logic rerr;
  int failures = 0;
  int n_checks = 0;

  // Clock
  always #5 pclk = ~pclk;

  hotplug_slot_control u_hotplug_slot_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_present(cap[0]), .power_ctrl_present(cap[1]), .latch_sensor_present(cap[2]),
    .attention_led_present(cap[3]), .power_led_present(cap[4]), .interlock_present(cap[5]),
    .hotplug_capable(cap[6]), .upstream_port(up), .button_pressed(ev[0]), .power_fault(ev[1]),
    .latch_changed(ev[2]), .presence_changed(ev[3]), .link_active(link), .cmd_req(cmd_req),
    .cmd_ack(cmd_ack), .attention_led(attention_led), .power_led(power_led),
    .slot_power_off(slot_power_off), .interlock_state(interlock_state), .hotplug_irq(hotplug_irq),
    .wake_event(wake_event)
  );

  hotplug_expander_model u_hotplug_expander_model (
    .pclk(pclk), .presetn(presetn), .cmd_req(cmd_req), .delay(dly), .cmd_ack(cmd_ack)
  );

  // Readable bits of the control register for a capability set
  function automatic logic [15:0] wmask(input logic [6:0] c);
    return {3'h0, 1'b1, 1'b0, c[1], c[4], c[4], c[3], c[3], c[6], c[6], 1'b1, c[2], c[1], c[0]};
  endfunction

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Comparison with mismatch report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait ran out
  task automatic timeout();
    failures++;
    $display("MISMATCH t=%0t wait ran out", $time);
    report_and_stop();
  endtask

  // One APB transfer; answer left in rdata and rerr
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 64 && pready !== 1'b1; i++) @(posedge pclk);
    if (pready !== 1'b1) timeout();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait until no command is outstanding
  task automatic wait_idle();
    int i;
    @(negedge pclk);
    for (i = 0; i < 64 && cmd_req !== 1'b0; i++) @(negedge pclk);
    if (cmd_req !== 1'b0) timeout();
  endtask

  // Reset with a capability set, then reset the bench model
  task automatic do_reset(input logic [6:0] c, input logic u);
    @(posedge pclk);
    presetn <= 1'b0;
    cap <= c;
    up <= u;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cur = 16'h01C0;
    ilk = 1'b0;
    pled = 2'h1;
  endtask

  // Control write, reserved indicator codes replaced, bench model updated
  task automatic ctl_wr(input logic [31:0] d);
    logic [15:0] m;
    m = wmask(cap);
    if (d[7:6] == 2'h0) d[7:6] = 2'h3;
    if (d[9:8] == 2'h0) d[9:8] = 2'h1;
    dly <= 4'($urandom_range(9, 0));
    apb(hotplug_pkg::SLOT_CONTROL_ADDR, 1'b1, d);
    cur = (cur & ~m) | (d[15:0] & m);
    if (cap[5] && d[11]) ilk = ~ilk;
    if (cap[4] && !up) pled = cur[9:8];
  endtask

  // Read back the control register and check the slot outputs
  task automatic rd_chk();
    wait_idle();
    apb(hotplug_pkg::SLOT_CONTROL_ADDR, 1'b0, 32'h00000000);
    chk(rdata, {16'h0000, cur & wmask(cap)});
    @(negedge pclk);
    if (cap[3]) chk(attention_led, cur[7:6]);
    if (cap[4]) chk(power_led, pled);
    if (cap[1]) chk(slot_power_off, cur[10]);
    chk(interlock_state, ilk);
  endtask

  // Raise one event with given enables and check flag, wake-up and interrupt
  task automatic ev_chk(input int f, input logic mst, input logic en);
    int sp;
    logic [31:0] c;
    sp = (f == 5) ? 8 : f;
    c = 32'h01C0 | (32'(mst) << 5) | (32'(en) << ((f == 5) ? 12 : f));
    ctl_wr(c);
    wait_idle();
    apb(hotplug_pkg::SLOT_STATUS_ADDR, 1'b1, 32'h000001FF);
    @(negedge pclk);
    chk({hotplug_irq, wake_event}, 2'h0);
    @(posedge pclk);
    if (f < 4) ev[f] <= 1'b1;
    if (f == 5) link <= ~link;
    @(posedge pclk);
    ev <= 4'h0;
    if (f == 4) ctl_wr(c);
    wait_idle();
    @(negedge pclk);
    chk({hotplug_irq, wake_event}, {en & mst, en & (f != 4)});
    apb(hotplug_pkg::SLOT_STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rdata, (32'h1 << sp) | (32'(ilk) << 7));
    apb(hotplug_pkg::SLOT_STATUS_ADDR, 1'b1, 32'h1 << sp);
    apb(hotplug_pkg::SLOT_STATUS_ADDR, 1'b0, 32'h00000000);
    chk(rdata, 32'(ilk) << 7);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h5051));
    do_reset(7'h7F, 1'b0);
    rd_chk();
    for (int k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      up <= (k >= 10);
      ctl_wr($urandom);
      ctl_wr($urandom);
      rd_chk();
    end
    apb(12'h100, 1'b1, 32'hFFFFFFFF);
    chk(rerr, 1'b1);
    apb(12'h100, 1'b0, 32'h00000000);
    chk(rdata, 32'h00000000);
    rd_chk();
    for (int m = 0; m < 4; m++)
      for (int f = 0; f < 6; f++)
        ev_chk(f, m[1], m[0]);
    for (int k = 0; k < 6; k++)
    begin
      do_reset(7'($urandom), 1'($urandom));
      repeat (4) ctl_wr($urandom);
      rd_chk();
    end
    report_and_stop();
  end
endmodule

bind hotplug_slot_control hotplug_slot_checker u_hotplug_slot_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .attention_led_present(attention_led_present),
  .power_led_present(power_led_present), .interlock_present(interlock_present),
  .upstream_port(upstream_port), .cmd_req(cmd_req), .cmd_ack(cmd_ack), .attention_led(attention_led),
  .power_led(power_led), .interlock_state(interlock_state)
);
